// ==== trig_qual_pkg.sv ====
// Package with register map, field positions and timing constants of the trigger qualifier
package trig_qual_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] CTRL_ADDR      = 8'h00;
  localparam logic [7:0] COND_ADDR      = 8'h04;
  localparam logic [7:0] REF_ADDR       = 8'h08;
  localparam logic [7:0] TOL_ADDR       = 8'h0c;
  localparam logic [7:0] LIM1_ADDR      = 8'h10;
  localparam logic [7:0] LIM2_ADDR      = 8'h14;
  localparam logic [7:0] HOLDOFF_ADDR   = 8'h18;
  localparam logic [7:0] LEVEL_ADDR     = 8'h1c;
  localparam logic [7:0] STATUS_ADDR    = 8'h20;
  localparam logic [7:0] COUNT_ADDR     = 8'h24;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTRL_LOGIC_SEL  = 0;  // Pattern type chosen
  localparam int CTRL_OR_OP      = 1;  // 1 = OR, 0 = AND
  localparam int CTRL_ON_FALSE   = 2;  // 1 = fire on pattern end
  localparam int CTRL_DUR_EN     = 3;  // Duration qualifier on
  localparam int CTRL_CRIT_LSB   = 4;  // Criterion, 3 bits
  localparam int CTRL_HOLD_OFF   = 7;  // 1 = hold-off disabled
  localparam int CTRL_EVENT_EN   = 8;  // Event pulse output enable
  localparam int CTRL_EXT_EN     = 9;  // External input enable
  localparam int CTRL_TB_LSB     = 12; // Time base code, 4 bits
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  // Condition register: care mask low byte, level byte above it
  localparam int COND_LEVEL_LSB  = 8;
  localparam logic [31:0] COND_RESET    = 32'h0000_0000;

  // Threshold preset register
  localparam int LEVEL_SEL_LSB   = 0;  // Preset select, 3 bits
  localparam int LEVEL_A_LSB     = 8;  // Custom level a, 8 bits
  localparam int LEVEL_B_LSB     = 16; // Custom level b, 8 bits
  localparam int LEVEL_EXT_LSB   = 24; // External input level, 8 bits
  localparam logic [31:0] LEVEL_RESET   = 32'h0000_0000;

  // Hold-off limits in ns and the 250 MHz clock period
  localparam longint HOLDOFF_MIN_NS = 50;
  localparam longint HOLDOFF_MAX_NS = 64'd10_000_000_000;
  localparam longint CLK_PERIOD_PS  = 4000;
  localparam logic [31:0] HOLDOFF_MIN_CYC =
    32'((HOLDOFF_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [31:0] HOLDOFF_MAX_CYC =
    32'((HOLDOFF_MAX_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [31:0] HOLDOFF_RESET   = HOLDOFF_MIN_CYC;

  // Duration comparison criteria
  typedef enum logic [2:0] {
    CRIT_NE, CRIT_EQ, CRIT_LT, CRIT_GT, CRIT_IN, CRIT_OUT, CRIT_TIMEOUT, CRIT_RSVD
  } crit_t;

  // Threshold presets
  typedef enum logic [2:0] {
    LVL_TTL, LVL_CMOS, LVL_ECL, LVL_CUSTOM_A, LVL_CUSTOM_B
  } level_sel_t;

endpackage

// ==== pattern_trigger_qualifier.sv ====
// Pattern trigger qualifier: pattern match, duration check, hold-off, event out
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module pattern_trigger_qualifier
  import trig_qual_pkg::*;
#(
  parameter int NUM_INPUTS = 8,
  parameter int CNT_W      = 32
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hsel,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [NUM_INPUTS-1:0] logic_in,
  input  wire logic                  analog_trig,
  input  wire logic                  external_trigger_input,
  output logic [2:0]                 level_select,
  output logic [7:0]                 custom_level_a,
  output logic [7:0]                 custom_level_b,
  output logic [7:0]                 external_input_level,
  output logic                       trigger_strobe,
  output logic                       aux_out
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  // input count
  if (NUM_INPUTS < 1 || NUM_INPUTS > 8) begin : g_bad_inputs
    $error("NUM_INPUTS must be 1 to 8");
  end
  if (CNT_W < 32) begin : g_bad_cnt
    $error("CNT_W too narrow for the maximum hold-off");
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] ctrl_q;
  logic [31:0] cond_q;
  logic [CNT_W-1:0] ref_q;
  logic [CNT_W-1:0] tol_q;
  logic [CNT_W-1:0] lim1_q;
  logic [CNT_W-1:0] lim2_q;
  logic [CNT_W-1:0] holdoff_q;
  logic [31:0] level_q;
  logic [31:0] trig_count_q;
  logic [31:0] rdata_d;
  logic        addr_ok;

  assign addr_ok = hsel && hready && htrans[1];

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q    <= CTRL_RESET;
      cond_q    <= COND_RESET;
      ref_q     <= '0;
      tol_q     <= '0;
      lim1_q    <= '0;
      lim2_q    <= '0;
      holdoff_q <= CNT_W'(HOLDOFF_RESET);
      level_q   <= LEVEL_RESET;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        CTRL_ADDR:    ctrl_q  <= hwdata;
        COND_ADDR:    cond_q  <= {16'h0000, hwdata[15:0]};
        REF_ADDR:     ref_q   <= CNT_W'(hwdata);
        TOL_ADDR:     tol_q   <= CNT_W'(hwdata);
        LIM1_ADDR:    lim1_q  <= CNT_W'(hwdata);
        LIM2_ADDR:    lim2_q  <= CNT_W'(hwdata);
        HOLDOFF_ADDR: begin
          if (hwdata < HOLDOFF_MIN_CYC) begin
            holdoff_q <= CNT_W'(HOLDOFF_MIN_CYC);
          end else if (hwdata > HOLDOFF_MAX_CYC) begin
            holdoff_q <= CNT_W'(HOLDOFF_MAX_CYC);
          end else begin
            holdoff_q <= CNT_W'(hwdata);
          end
        end
        LEVEL_ADDR:   level_q <= hwdata;
        default: ;
      endcase
    end
  end

  // Read data mux, unmapped reads zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (haddr[7:0])
      CTRL_ADDR:    rdata_d = ctrl_q;
      COND_ADDR:    rdata_d = cond_q;
      REF_ADDR:     rdata_d = 32'(ref_q);
      TOL_ADDR:     rdata_d = 32'(tol_q);
      LIM1_ADDR:    rdata_d = 32'(lim1_q);
      LIM2_ADDR:    rdata_d = 32'(lim2_q);
      HOLDOFF_ADDR: rdata_d = 32'(holdoff_q);
      LEVEL_ADDR:   rdata_d = level_q;
      STATUS_ADDR:  rdata_d = status_word();
      COUNT_ADDR:   rdata_d = trig_count_q;
      default:      rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data registered for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      if (addr_ok && !hwrite) begin
        hrdata <= rdata_d;
      end
    end
  end

  // ****************************************
  // Threshold presets
  // ****************************************
  // level select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_select         <= 3'h0;
      custom_level_a       <= 8'h00;
      custom_level_b       <= 8'h00;
      external_input_level <= 8'h00;
    end else begin
      level_select         <= (level_q[LEVEL_SEL_LSB +: 3] > 3'(LVL_CUSTOM_B)) ?
                              3'(LVL_TTL) : level_q[LEVEL_SEL_LSB +: 3];
      custom_level_a       <= level_q[LEVEL_A_LSB +: 8];
      custom_level_b       <= level_q[LEVEL_B_LSB +: 8];
      external_input_level <= level_q[LEVEL_EXT_LSB +: 8];
    end
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [NUM_INPUTS-1:0] in_meta_q;
  logic [NUM_INPUTS-1:0] in_sync_q;
  logic [1:0]            ext_meta_q;
  logic                  ext_sync_q;
  logic                  ana_sync_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_meta_q  <= '0;
      in_sync_q  <= '0;
      ext_meta_q <= 2'h0;
      ext_sync_q <= 1'b0;
      ana_sync_q <= 1'b0;
    end else begin
      in_meta_q  <= logic_in;
      in_sync_q  <= in_meta_q;
      ext_meta_q <= {analog_trig, external_trigger_input};
      ext_sync_q <= ext_meta_q[0];
      ana_sync_q <= ext_meta_q[1];
    end
  end

  // ****************************************
  // Pattern match
  // ****************************************
  logic [NUM_INPUTS-1:0] care;
  logic [NUM_INPUTS-1:0] want;
  logic [NUM_INPUTS-1:0] hit;
  logic                  pattern;
  logic                  pattern_q;

  assign care = cond_q[NUM_INPUTS-1:0];
  assign want = cond_q[COND_LEVEL_LSB +: NUM_INPUTS];

  assign hit = ~(in_sync_q ^ want);

  always_comb begin
    if (ctrl_q[CTRL_OR_OP]) begin
      pattern = |(hit & care);
    end else begin
      pattern = &(hit | ~care) && (|care);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pattern_q <= 1'b0;
    end else begin
      pattern_q <= pattern;
    end
  end

  // ****************************************
  // Duration measurement
  // ****************************************
  logic [CNT_W-1:0] dur_q;
  logic             to_done_q;
  logic             fire;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dur_q     <= '0;
      to_done_q <= 1'b0;
    end else if (pattern) begin
      if (!pattern_q) begin
        dur_q     <= CNT_W'(1);
        to_done_q <= 1'b0;
      end else if (dur_q != '1) begin
        dur_q <= dur_q + CNT_W'(1);
      end
      if (fire) begin
        to_done_q <= 1'b1;
      end
    end else begin
      to_done_q <= 1'b0;
    end
  end

  // Duration compare against criterion
  function automatic logic dur_match(input logic [2:0] crit, input logic [CNT_W-1:0] d);
    logic [CNT_W:0] lo;
    logic [CNT_W:0] hi;
    logic           in_band;
    lo      = (tol_q > ref_q) ? '0 : {1'b0, ref_q - tol_q};
    hi      = {1'b0, ref_q} + {1'b0, tol_q};
    in_band = ({1'b0, d} >= lo) && ({1'b0, d} <= hi);
    case (crit)
      3'(CRIT_EQ):  dur_match = in_band;
      3'(CRIT_NE):  dur_match = !in_band;
      3'(CRIT_LT):  dur_match = d < ref_q;
      3'(CRIT_GT):  dur_match = d > ref_q;
      3'(CRIT_IN):  dur_match = (d > lim1_q) && (d < lim2_q);
      3'(CRIT_OUT): dur_match = !((d > lim1_q) && (d < lim2_q));
      default:      dur_match = 1'b0;
    endcase
  endfunction

  // ****************************************
  // Trigger decision
  // ****************************************
  logic       rise;
  logic       fall;
  logic [2:0] crit;
  logic       cand;
  logic       ext_q;

  assign rise = pattern && !pattern_q;
  assign fall = !pattern && pattern_q;
  assign crit = ctrl_q[CTRL_CRIT_LSB +: 3];

  always_comb begin
    fire = 1'b0;
    if (ctrl_q[CTRL_DUR_EN]) begin
      if (crit == 3'(CRIT_TIMEOUT)) begin
        fire = pattern && pattern_q && !to_done_q && (dur_q == ref_q);
      end else begin
        fire = fall && dur_match(crit, dur_q);
      end
    end else begin
      fire = ctrl_q[CTRL_ON_FALSE] ? fall : rise;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_sync_q;
    end
  end

  assign cand = (ctrl_q[CTRL_LOGIC_SEL] ? fire : ana_sync_q)
              || (ctrl_q[CTRL_EXT_EN] && ext_sync_q && !ext_q);

  // ****************************************
  // Hold-off and strobe
  // ****************************************
  logic [CNT_W-1:0] hold_cnt_q;
  logic             armed;

  assign armed = ctrl_q[CTRL_HOLD_OFF] || (hold_cnt_q == '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trigger_strobe <= 1'b0;
    end else begin
      trigger_strobe <= cand && armed;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_cnt_q <= '0;
    end else if (cand && armed && !ctrl_q[CTRL_HOLD_OFF]) begin
      hold_cnt_q <= holdoff_q;
    end else if (hold_cnt_q != '0) begin
      hold_cnt_q <= hold_cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aux_out <= 1'b0;
    end else begin
      aux_out <= cand && armed && ctrl_q[CTRL_EVENT_EN];
    end
  end

  // Trigger counter for software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_count_q <= 32'h0000_0000;
    end else if (trigger_strobe) begin
      trig_count_q <= trig_count_q + 32'h0000_0001;
    end
  end

  // Status word: pattern, armed, inputs
  function automatic logic [31:0] status_word();
    status_word = {22'h000000, armed, pattern_q, 8'(in_sync_q)};
  endfunction

endmodule

// ==== pattern_trigger_qualifier_checker.sv ====
// Checker of bus answers and trigger output relations
`timescale 1ns/10ps
module pattern_trigger_qualifier_checker
  import trig_qual_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [2:0]  level_select,
  input wire logic [7:0]  custom_level_a,
  input wire logic        trigger_strobe,
  input wire logic        aux_out
);
  // ****************************************
  // Data phase tracking and control shadow
  // ****************************************
  logic       wr_q;
  logic       rd_q;
  logic       ev_en_q;
  logic       ho_off_q;
  logic [7:0] a_q;
  // Shadow of the event enable and hold-off control bits written over the bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      ev_en_q  <= 1'b0;
      ho_off_q <= 1'b0;
      a_q      <= 8'h00;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
      rd_q <= hsel && hready && htrans[1] && !hwrite;
      a_q  <= haddr[7:0];
      if (wr_q && a_q == CTRL_ADDR) begin
        ev_en_q  <= hwdata[CTRL_EVENT_EN];
        ho_off_q <= hwdata[CTRL_HOLD_OFF];
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_lvl_wr;
    wr_q && a_q == LEVEL_ADDR;
  endsequence
  a_ready_always: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_rdata_hold: assert property ($changed(hrdata) |-> rd_q || $past(rd_q))
    else $error("hrdata moved without read");
  a_aux_cause: assert property (aux_out |-> trigger_strobe && ev_en_q)
    else $error("aux pulse without enabled strobe");
  a_event_pulse: assert property (trigger_strobe && ev_en_q |-> aux_out)
    else $error("strobe without aux pulse");
  a_holdoff_gap: assert property (trigger_strobe && !ho_off_q |=> !trigger_strobe [*8])
    else $error("strobe inside hold-off");
  // Register lands at the write edge, the output copy one edge later
  a_level_sel: assert property (s_lvl_wr |=> ##1 level_select ==
    (($past(hwdata[2:0], 2) > 3'(LVL_CUSTOM_B)) ? 3'(LVL_TTL) : $past(hwdata[2:0], 2)))
    else $error("preset select not copied");
  a_level_custom: assert property (s_lvl_wr |=> ##1 custom_level_a == $past(hwdata[15:8], 2))
    else $error("custom level not copied");
endmodule
bind pattern_trigger_qualifier pattern_trigger_qualifier_checker u_chk (.hclk, .hresetn,
  .haddr, .htrans, .hwrite, .hsel, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
  .level_select, .custom_level_a, .trigger_strobe, .aux_out);

// ==== probe_source.sv ====
// Model of the probed digital signals and the external trigger source
`timescale 1ns/10ps
module probe_source (
  input  wire logic       hclk,
  input  wire logic [7:0] want,
  input  wire logic       ext_want,
  output logic      [7:0] logic_in,
  output logic            external_trigger_input
);
  // Probe levels move just after each edge, unrelated to bus traffic
  always_ff @(posedge hclk) begin
    logic_in               <= want;
    external_trigger_input <= ext_want;
  end
endmodule

// ==== tb.sv ====
// Self-checking bench for the pattern trigger qualifier
`timescale 1ns/10ps
module tb;
  import trig_qual_pkg::*;
  logic        hclk, hresetn, hwrite, hsel, analog_trig, ext_want;
  logic        hreadyout, hresp, ext_in, trigger_strobe, aux_out;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [7:0]  want, logic_in, lvl_a, lvl_b, lvl_e;
  logic [2:0]  lvl_sel;
  int          n_fail, n_tests, n_strobe, n_aux;
  pattern_trigger_qualifier dut (.hclk, .hresetn, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hsel, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .logic_in,
    .analog_trig, .external_trigger_input(ext_in), .level_select(lvl_sel),
    .custom_level_a(lvl_a), .custom_level_b(lvl_b), .external_input_level(lvl_e),
    .trigger_strobe, .aux_out);
  probe_source u_src (.hclk, .want, .ext_want, .logic_in, .external_trigger_input(ext_in));
  // ****************************************
  // Clock, pulse counters and helpers
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Count strobes and aux pulses away from the rising edge
  always @(negedge hclk) begin
    if (trigger_strobe === 1'b1) n_strobe++;
    if (aux_out === 1'b1) n_aux++;
  end
  task automatic finish_test();
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // One single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // Hold a probe pattern for w cycles, count strobes during and after
  task automatic pulse(input logic [7:0] v, input int w, output int in_c, output int tot);
    int s0;
    s0 = n_strobe;
    want <= v;
    cyc(w);
    in_c = n_strobe - s0;
    want <= 8'h00;
    cyc(12);
    tot = n_strobe - s0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rdchk(CTRL_ADDR, CTRL_RESET);
    rdchk(HOLDOFF_ADDR, HOLDOFF_RESET);
    rdchk(8'h30, 32'h0);
    wr(HOLDOFF_ADDR, 32'h5);
    rdchk(HOLDOFF_ADDR, HOLDOFF_MIN_CYC);
    wr(HOLDOFF_ADDR, 32'hffff_ffff);
    rdchk(HOLDOFF_ADDR, HOLDOFF_MAX_CYC);
    wr(HOLDOFF_ADDR, 32'h28);
    wr(CTRL_ADDR, 32'h0000_f000);
    rdchk(HOLDOFF_ADDR, 32'h28);
  endtask
  task automatic t_levels();
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      d = {8'(i + 3), 8'(i + 2), 8'(i + 1), 5'h0, 3'(i)};
      wr(LEVEL_ADDR, d);
      cyc(2);
      chk({lvl_e, lvl_b, lvl_a, 5'h0, lvl_sel}, d);
    end
  endtask
  task automatic t_pattern();
    int ic, t, a0;
    wr(COND_ADDR, 32'h0103);
    wr(CTRL_ADDR, 32'h181);
    a0 = n_aux;
    pulse(8'h01, 6, ic, t);
    chk(32'(t), 1);
    chk(32'(n_aux - a0), 1);
    pulse(8'hfd, 6, ic, t);
    chk(32'(t), 1);
    pulse(8'h03, 6, ic, t);
    chk(32'(t), 0);
    analog_trig <= 1'b1;
    pulse(8'h00, 6, ic, t);
    analog_trig <= 1'b0;
    chk(32'(t), 0);
    wr(COND_ADDR, 32'h0303);
    wr(CTRL_ADDR, 32'h183);
    pulse(8'h02, 6, ic, t);
    chk(32'(t), 1);
    wr(CTRL_ADDR, 32'h185);
    wr(COND_ADDR, 32'h0103);
    pulse(8'h01, 8, ic, t);
    chk(32'({ic[3:0], t[3:0]}), 32'h01);
    wr(CTRL_ADDR, 32'h081);
    a0 = n_aux;
    pulse(8'h01, 6, ic, t);
    chk(32'({n_aux[3:0] - a0[3:0], t[3:0]}), 32'h01);
  endtask
  task automatic t_dur();
    int w[14] = '{15, 10, 12, 13, 9, 10, 11, 10, 7, 10, 12, 7, 40, 9};
    int ic, t, e;
    wr(COND_ADDR, 32'h0101);
    wr(REF_ADDR, 32'd10);
    wr(TOL_ADDR, 32'd2);
    wr(LIM1_ADDR, 32'd5);
    wr(LIM2_ADDR, 32'd10);
    for (int i = 0; i < 14; i++) begin
      e = (i % 2 == 0) ? 1 : 0;
      wr(CTRL_ADDR, 32'h89 | 32'((i / 2) << CTRL_CRIT_LSB));
      pulse(8'h01, w[i], ic, t);
      chk(32'(t), 32'(e));
      chk(32'(ic), (i / 2 == 6) ? 32'(e) : 32'h0);
    end
  endtask
  task automatic t_holdoff();
    int s0;
    wr(CTRL_ADDR, 32'h0);
    s0 = n_strobe;
    analog_trig <= 1'b1;
    cyc(100);
    chk(32'(n_strobe - s0 inside {[2:3]}), 1);
    wr(CTRL_ADDR, 32'h80);
    s0 = n_strobe;
    cyc(20);
    analog_trig <= 1'b0;
    chk(32'(n_strobe - s0 >= 10), 1);
  endtask
  task automatic t_ext();
    int s0;
    wr(COND_ADDR, 32'h0);
    for (int en = 0; en < 2; en++) begin
      wr(CTRL_ADDR, en ? 32'h281 : 32'h081);
      s0 = n_strobe;
      ext_want <= 1'b1;
      cyc(4);
      ext_want <= 1'b0;
      cyc(8);
      chk(32'(n_strobe - s0), 32'(en));
    end
    rdchk(COUNT_ADDR, 32'(n_strobe));
  endtask
  // Reset, then the scenarios in turn
  initial begin
    {hresetn, hsel, hwrite, analog_trig, ext_want} = 5'h0;
    {haddr, hwdata, htrans, want} = '0;
    {n_fail, n_tests, n_strobe, n_aux} = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_levels();
    t_pattern();
    t_dur();
    t_holdoff();
    t_ext();
    finish_test();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    finish_test();
  end
endmodule
